// *** logic/sasc_ctrl.sv ***
// Sequencer, sample timing, approximation and prescaler of the converter
//
// Notes on behaviour
// - Mux routes one of eight channels.
// - Phase one lasts two module clocks.
// - Phase two lasts four module clocks.
// - Phase three lasts 2, 4, 8, 16 clocks.
// - Binary search over sample, 8/10 bits.
// - Conversion 10 or 12 clocks, then store.
// - Five-bit modulus prescaler divides by 1..32.
// - Prescaler output halved gives module clock.
// - Power down on bit, stop, or wait.
// - Power-up bit resets to zero.
// - Power-down stops clocks; bit or stop also aborts sequence.
// - Registers stay accessible except in wait power-down.
// - Wait ignored unless stop-in-wait set.
// - Idle submodules gate their clocks off.
// - Freeze field: ignore, finish, or immediate.
// - Frozen state holds; resumes on release.
// - System or test reset resets module.
// - Module reset clears sequence and flags.
// - Wait resumes; finish-freeze leaves idle.
// - Control four/five write restarts sequence.
// - Module clock phase locked to clk.
// - Done flag per sequence, ready per result.
// - Sequences of one, four, eight conversions.
`default_nettype none
module sasc_ctrl (
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire logic                       power_up_wr,
  input  wire logic                       power_up_in,
  input  wire logic                       stop_in_wait_in,
  input  wire logic [1:0]                 freeze_sel,
  input  wire logic                       test_rst,
  input  wire logic                       stop_req,
  input  wire logic                       wait_req,
  input  wire logic                       debug_halt_request,
  input  wire logic [4:0]                 prescale_sel,
  input  wire logic [1:0]                 sample_time_sel,
  input  wire logic                       res10_sel,
  input  wire logic                       just_right,
  input  wire logic                       ctrl_four_wr,
  input  wire logic                       ctrl_five_wr,
  input  wire sasc_pkg::sasc_seq_t        seq_cfg,
  input  wire logic [7:0]                 ready_clr,
  input  wire logic                       done_clr,
  input  wire logic                       compare_hi,
  output logic                            power_up_ctl,
  output logic                            stop_in_wait,
  output sasc_pkg::sasc_afe_t             afe,
  output logic [sasc_pkg::RES_W-1:0]      dac_code,
  output logic                            result_we,
  output logic [2:0]                      result_slot,
  output logic [15:0]                     result_word,
  output logic [7:0]                      result_ready_flag,
  output logic                            sequence_done_flag,
  output logic                            busy,
  output logic                            regs_accessible
);
  sasc_pkg::sasc_state_t s_ff;
  sasc_pkg::sasc_state_t nxt_s;
  logic power_up_ff;
  logic nxt_power_up;
  logic asw_ff;
  logic nxt_asw;
  logic [1:0] stop_sync_ff;
  logic [1:0] wait_sync_ff;
  logic [1:0] halt_sync_ff;
  logic [15:0] res_word_ff;
  logic [15:0] nxt_res_word;
  logic busy_ff;
  logic acc_ff;

  //////////////////////////////////////////////////////////////////////////
  // Pin-side requests are synchronised before use
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stop_sync_ff <= 2'h0;
      wait_sync_ff <= 2'h0;
      halt_sync_ff <= 2'h0;
    end else begin
      stop_sync_ff <= {stop_sync_ff[0], stop_req};
      wait_sync_ff <= {wait_sync_ff[0], wait_req};
      halt_sync_ff <= {halt_sync_ff[0], debug_halt_request};
    end
  end

  logic stop_s;
  logic wait_s;
  logic halt_s;
  logic pdown;
  logic mreset;
  logic restart;
  logic mclk_en;
  logic [4:0] ph3_len;
  logic [3:0] top_bit;
  logic [3:0] seq_len;
  assign stop_s  = stop_sync_ff[1];
  assign wait_s  = wait_sync_ff[1];
  assign halt_s  = halt_sync_ff[1];
  assign mreset  = sys_rst | test_rst;
  // Wait only counts when the stop-in-wait bit allows it
  assign pdown   = ~power_up_ff | stop_s | (wait_s & asw_ff);
  assign restart = ctrl_four_wr | ctrl_five_wr;
  // Sample phase three length from the selection field
  assign ph3_len = 5'(2) << sample_time_sel;
  assign top_bit = res10_sel ? 4'h9 : 4'h7;
  assign seq_len = s_ff.seq.length_eight_sel ? 4'h8 :
                   (s_ff.seq.length_one_sel ? 4'h1 : 4'h4);

  //////////////////////////////////////////////////////////////////////////
  // Control bits: a test reset keeps the power-up bit
  always_comb begin
    nxt_power_up = power_up_ff;
    nxt_asw      = asw_ff;
    if (power_up_wr) begin
      nxt_power_up = power_up_in;
      nxt_asw      = stop_in_wait_in;
    end
    if (test_rst)
      nxt_asw = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      power_up_ff <= 1'b0;
      asw_ff      <= 1'b0;
      acc_ff      <= 1'b1;
    end else begin
      power_up_ff <= nxt_power_up;
      asw_ff      <= nxt_asw;
      // Registered output, so access drops one cycle after the wait
      acc_ff      <= ~(wait_s & nxt_asw);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Prescaler and divide-by-two give a one-cycle module clock enable;
  // the counters run off clk so the phase relation is fixed
  always_comb begin
    logic frz_now;
    logic hold;
    logic last_conv;
    frz_now   = 1'b0;
    hold      = 1'b0;
    last_conv = 1'b0;
    nxt_s = s_ff;
    nxt_s.res_we = 1'b0;
    mclk_en = 1'b0;
    // Wait power-down holds everything so the sequence resumes later
    frz_now = s_ff.frozen;
    hold = pdown | frz_now;
    if (!hold) begin
      if (s_ff.pre_cnt >= prescale_sel) begin
        nxt_s.pre_cnt = '0;
        nxt_s.half = ~s_ff.half;
        mclk_en = s_ff.half;
      end else begin
        nxt_s.pre_cnt = s_ff.pre_cnt + 5'h01;
      end
    end

    // Freeze handling
    if (halt_s) begin
      case (sasc_pkg::sasc_frz_t'(freeze_sel))
        sasc_pkg::SASC_FRZ_NOW:    nxt_s.frozen = 1'b1;
        sasc_pkg::SASC_FRZ_FINISH: nxt_s.frz_pend = 1'b1;
        default: ;
      endcase
    end else begin
      nxt_s.frozen   = 1'b0;
      nxt_s.frz_pend = 1'b0;
    end

    if (mclk_en) begin
      case (s_ff.st)
        sasc_pkg::SASC_PH1: begin
          if (s_ff.ph_cnt == 5'(sasc_pkg::PH1_CLKS - 1)) begin
            nxt_s.st = sasc_pkg::SASC_PH2;
            nxt_s.ph_cnt = '0;
          end else nxt_s.ph_cnt = s_ff.ph_cnt + 5'h01;
        end
        sasc_pkg::SASC_PH2: begin
          if (s_ff.ph_cnt == 5'(sasc_pkg::PH2_CLKS - 1)) begin
            nxt_s.st = sasc_pkg::SASC_PH3;
            nxt_s.ph_cnt = '0;
          end else nxt_s.ph_cnt = s_ff.ph_cnt + 5'h01;
        end
        sasc_pkg::SASC_PH3: begin
          if (s_ff.ph_cnt == ph3_len - 5'h01) begin
            nxt_s.st = sasc_pkg::SASC_CONV;
            nxt_s.ph_cnt = '0;
            nxt_s.approximation_register = '0;
            nxt_s.approximation_register[top_bit] = 1'b1;
            nxt_s.bit_idx = top_bit;
          end else nxt_s.ph_cnt = s_ff.ph_cnt + 5'h01;
        end
        sasc_pkg::SASC_CONV: begin
          nxt_s.ph_cnt = s_ff.ph_cnt + 5'h01;
          // One trial bit per clock, keep it if the sample is higher
          if (s_ff.ph_cnt <= 5'(top_bit)) begin
            if (!compare_hi)
              nxt_s.approximation_register[s_ff.bit_idx] = 1'b0;
            if (s_ff.bit_idx != 4'h0) begin
              nxt_s.approximation_register[s_ff.bit_idx - 4'h1] = 1'b1;
              nxt_s.bit_idx = s_ff.bit_idx - 4'h1;
            end
          end
          if (s_ff.ph_cnt == 5'(res10_sel ? sasc_pkg::CONV10_CLKS - 1
                                          : sasc_pkg::CONV8_CLKS - 1)) begin
            nxt_s.res_we = 1'b1;
            nxt_s.res_data = s_ff.approximation_register;
            nxt_s.res_slot = s_ff.conv_idx;
            nxt_s.ready[s_ff.conv_idx] = 1'b1;
            nxt_s.ph_cnt = '0;
            last_conv = ({1'b0, s_ff.conv_idx} + 4'h1 == seq_len);
            if (s_ff.seq.multi_channel_sel)
              nxt_s.afe.mux_sel = s_ff.afe.mux_sel + 3'h1;
            if (last_conv) begin
              nxt_s.seq_done = 1'b1;
              nxt_s.conv_idx = '0;
              nxt_s.afe.mux_sel = s_ff.seq.chan;
            end else nxt_s.conv_idx = s_ff.conv_idx + 3'h1;
            // Next channel starts at once unless done without scan or freeze pending
            if ((last_conv && !s_ff.seq.scan) || s_ff.frz_pend)
              nxt_s.st = sasc_pkg::SASC_IDLE;
            else
              nxt_s.st = sasc_pkg::SASC_PH1;
          end
        end
        default: ;
      endcase
    end

    // Software clears; a simultaneous set wins
    for (int i = 0; i < sasc_pkg::NUM_CH; i++)
      if (ready_clr[i] && !(nxt_s.res_we && nxt_s.res_slot == 3'(i)))
        nxt_s.ready[i] = 1'b0;
    if (done_clr && !(nxt_s.seq_done && !s_ff.seq_done))
      nxt_s.seq_done = 1'b0;

    if (restart) begin
      nxt_s.st = sasc_pkg::SASC_PH1;
      nxt_s.seq = seq_cfg;
      nxt_s.ph_cnt = '0;
      nxt_s.conv_idx = '0;
      nxt_s.ready = '0;
      nxt_s.seq_done = 1'b0;
      nxt_s.afe.mux_sel = seq_cfg.chan;
      // Divider restarts so every sequence sees whole module clocks
      nxt_s.pre_cnt = '0;
      nxt_s.half = 1'b0;
    end
    // The power-up bit or a stop aborts; a wait only holds and resumes
    if (~power_up_ff | stop_s) begin
      nxt_s.st = sasc_pkg::SASC_IDLE;
      nxt_s.ph_cnt = '0;
      nxt_s.conv_idx = '0;
    end

    nxt_s.afe.powered = ~pdown;
    nxt_s.afe.ph1_sample_cap = (nxt_s.st == sasc_pkg::SASC_PH1) & ~pdown;
    nxt_s.afe.ph2_buffer_amp = (nxt_s.st == sasc_pkg::SASC_PH2) & ~pdown;
    nxt_s.afe.ph3_direct = (nxt_s.st == sasc_pkg::SASC_PH3) & ~pdown;
    nxt_s.afe.sh_clk_en = (nxt_s.st != sasc_pkg::SASC_IDLE) &
                          (nxt_s.st != sasc_pkg::SASC_CONV) &
                          ~pdown & ~nxt_s.frozen;
    nxt_s.afe.conv_clk_en = (nxt_s.st == sasc_pkg::SASC_CONV) &
                            ~pdown & ~nxt_s.frozen;
  end

  always_comb begin
    nxt_res_word = res_word_ff;
    if (s_ff.res_we) begin
      if (res10_sel)
        nxt_res_word = just_right ? {6'h00, s_ff.res_data}
                                  : {s_ff.res_data, 6'h00};
      else
        nxt_res_word = just_right ? {8'h00, s_ff.res_data[7:0]}
                                  : {s_ff.res_data[7:0], 8'h00};
    end
  end

  always_ff @(posedge clk) begin
    if (mreset) begin
      s_ff        <= '0;
      s_ff.st     <= sasc_pkg::SASC_IDLE;
      s_ff.pre_cnt <= sasc_pkg::PRE_RST;
      res_word_ff <= 16'h0000;
      busy_ff     <= 1'b0;
    end else begin
      s_ff        <= nxt_s;
      res_word_ff <= nxt_res_word;
      busy_ff     <= nxt_s.st != sasc_pkg::SASC_IDLE;
    end
  end

  assign power_up_ctl       = power_up_ff;
  assign stop_in_wait       = asw_ff;
  assign afe                = s_ff.afe;
  assign dac_code           = s_ff.approximation_register;
  assign result_we          = s_ff.res_we;
  assign result_slot        = s_ff.res_slot;
  assign result_word        = res_word_ff;
  assign result_ready_flag  = s_ff.ready;
  assign sequence_done_flag = s_ff.seq_done;
  assign busy               = busy_ff;
  assign regs_accessible    = acc_ff;
endmodule
`default_nettype wire

// *** logic/sasc_pkg.sv ***
// Package: constants and carriers for the converter sequencer control
`default_nettype none
package sasc_pkg;
  localparam int NUM_CH       = 8;
  localparam int CH_W         = 3;
  localparam int PRE_W        = 5;
  localparam int PH1_CLKS     = 2;
  localparam int PH2_CLKS     = 4;
  localparam int CONV8_CLKS   = 10;
  localparam int CONV10_CLKS  = 12;
  localparam int CNT_W        = 5;
  localparam int RES_W        = 10;
  localparam logic [4:0] PRE_RST = 5'h01;

  typedef enum logic [4:0] {
    SASC_IDLE = 5'b00001,
    SASC_PH1  = 5'b00010,
    SASC_PH2  = 5'b00100,
    SASC_PH3  = 5'b01000,
    SASC_CONV = 5'b10000
  } sasc_st_t;

  typedef enum logic [1:0] {
    SASC_FRZ_IGNORE = 2'h0,
    SASC_FRZ_RSVD   = 2'h1,
    SASC_FRZ_FINISH = 2'h2,
    SASC_FRZ_NOW    = 2'h3
  } sasc_frz_t;

  // Sequence configuration latched on a restart
  typedef struct packed {
    logic            multi_channel_sel;
    logic            scan;
    logic            length_one_sel;
    logic            length_eight_sel;
    logic [CH_W-1:0] chan;
  } sasc_seq_t;

  // Analog front end strobes
  typedef struct packed {
    logic            powered;
    logic [CH_W-1:0] mux_sel;
    logic            ph1_sample_cap;
    logic            ph2_buffer_amp;
    logic            ph3_direct;
    logic            sh_clk_en;
    logic            conv_clk_en;
  } sasc_afe_t;

  typedef struct packed {
    sasc_st_t         st;
    sasc_seq_t        seq;
    logic [PRE_W-1:0] pre_cnt;
    logic             half;
    logic [CNT_W-1:0] ph_cnt;
    logic [3:0]       bit_idx;
    logic [RES_W-1:0] approximation_register;
    logic [2:0]       conv_idx;
    logic [2:0]       res_slot;
    logic             res_we;
    logic [RES_W-1:0] res_data;
    logic [NUM_CH-1:0] ready;
    logic             seq_done;
    logic             frz_pend;
    logic             frozen;
    sasc_afe_t        afe;
  } sasc_state_t;
endpackage
`default_nettype wire

// *** sim/sasc_ctrl_chk.sv ***
// Port checker for the converter sequencer control
`default_nettype none
module sasc_ctrl_chk (
  input wire logic                clk,
  input wire logic                sys_rst,
  input wire logic                ctrl_four_wr,
  input wire logic                ctrl_five_wr,
  input wire logic                test_rst,
  input wire logic [4:0]          prescale_sel,
  input wire logic [1:0]          sample_time_sel,
  input wire logic                power_up_ctl,
  input wire sasc_pkg::sasc_afe_t afe,
  input wire logic                result_we,
  input wire logic [2:0]          result_slot,
  input wire logic [7:0]          result_ready_flag,
  input wire logic                sequence_done_flag,
  input wire logic                busy
);
  logic [11:0] len1_ff;
  logic [11:0] len2_ff;
  logic [11:0] len3_ff;
  logic [11:0] mclk;
  logic        rs_wr;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////
  // One module clock in clk cycles; settings only change while idle
  assign mclk = {6'h00, prescale_sel, 1'h0} + 12'h002;

  // A restart begins a fresh first phase even if the strobe stays high
  assign rs_wr = ctrl_four_wr | ctrl_five_wr;

  always_ff @(posedge clk) begin
    len1_ff <= afe.ph1_sample_cap && !rs_wr ? len1_ff + 12'h001 : 12'h000;
    len2_ff <= afe.ph2_buffer_amp && !rs_wr ? len2_ff + 12'h001 : 12'h000;
    len3_ff <= afe.ph3_direct && !rs_wr ? len3_ff + 12'h001 : 12'h000;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_phase_one_hot: assert property (
    $onehot0({afe.ph1_sample_cap, afe.ph2_buffer_amp, afe.ph3_direct}))
    else $error("sampling phases overlap");
  a_reset_idle: assert property (
    $fell(sys_rst) |-> !power_up_ctl && !busy && result_ready_flag == 8'h00)
    else $error("state after reset not idle");
  a_ph1_len: assert property (
    $fell(afe.ph1_sample_cap) && afe.ph2_buffer_amp |-> len1_ff == mclk * 2)
    else $error("first phase length wrong");
  a_ph2_len: assert property (
    $fell(afe.ph2_buffer_amp) && afe.ph3_direct |-> len2_ff == mclk * 4)
    else $error("second phase length wrong");
  a_ph3_len: assert property (
    $fell(afe.ph3_direct) && afe.conv_clk_en
    |-> len3_ff == mclk << (sample_time_sel + 1))
    else $error("third phase length wrong");
  a_restart_clear: assert property (
    (ctrl_four_wr || ctrl_five_wr) && power_up_ctl && !test_rst |=>
    !sequence_done_flag && result_ready_flag == 8'h00 ##[0:1]
    afe.ph1_sample_cap) else $error("restart did not clear and sample");
  a_test_reset: assert property (
    test_rst && power_up_ctl |=> power_up_ctl && !busy
    && !sequence_done_flag && result_ready_flag == 8'h00)
    else $error("test reset left state behind");
  a_ready_set: assert property (
    result_we |=> result_ready_flag[$past(result_slot)])
    else $error("ready flag not set for stored slot");
  a_power_down: assert property (
    !power_up_ctl [*2] |-> !busy && !afe.powered && !afe.sh_clk_en
    && !afe.conv_clk_en) else $error("powered-down block still active");
  a_idle_gated: assert property (
    !busy [*2] |-> !afe.sh_clk_en && !afe.conv_clk_en)
    else $error("idle submodule clock running");
endmodule

bind sasc_ctrl sasc_ctrl_chk i_sasc_ctrl_chk (.clk, .sys_rst, .ctrl_four_wr,
  .ctrl_five_wr, .test_rst, .prescale_sel, .sample_time_sel, .power_up_ctl,
  .afe, .result_we, .result_slot, .result_ready_flag, .sequence_done_flag,
  .busy);
`default_nettype wire

// *** sim/sasc_ctrl_tb.sv ***
// Self-checking bench for the converter sequencer control
`default_nettype none
module sasc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk = '0, sys_rst = '1, power_up_wr = '0;
  logic                power_up_in = '0, stop_in_wait_in = '0;
  logic                test_rst = '0, stop_req = '0, wait_req = '0;
  logic                debug_halt_request = '0, res10_sel = '0;
  logic                just_right = '0, ctrl_four_wr = '0;
  logic                ctrl_five_wr = '0, done_clr = '0, compare_hi = '0;
  logic [1:0]          freeze_sel = '0, sample_time_sel = '0;
  logic [4:0]          prescale_sel = '0;
  logic [7:0]          ready_clr = '0, result_ready_flag;
  logic [9:0]          dac_code, target = '0;
  logic [2:0]          result_slot;
  logic [15:0]         result_word;
  logic                power_up_ctl, stop_in_wait, result_we, busy;
  logic                sequence_done_flag, regs_accessible;
  sasc_pkg::sasc_seq_t seq_cfg = '0;
  sasc_pkg::sasc_afe_t afe;
  int                  n_fail = 0, tests_run = 0, lat;

  sasc_ctrl i_sasc_ctrl (.clk, .sys_rst, .power_up_wr, .power_up_in,
    .stop_in_wait_in, .freeze_sel, .test_rst, .stop_req, .wait_req,
    .debug_halt_request, .prescale_sel, .sample_time_sel, .res10_sel,
    .just_right, .ctrl_four_wr, .ctrl_five_wr, .seq_cfg, .ready_clr,
    .done_clr, .compare_hi, .power_up_ctl, .stop_in_wait, .afe, .dac_code,
    .result_we, .result_slot, .result_word, .result_ready_flag,
    .sequence_done_flag, .busy, .regs_accessible);

  always #5 clk = ~clk;
  // Sample sits half a step above target, so no comparison is ever a tie
  always @(negedge clk) compare_hi <= dac_code <= target;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    if (n_fail == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk) s = 1'h1;
    @(negedge clk) s = 1'h0;
  endtask

  task automatic power(input logic on, input logic siw);
    power_up_in = on;
    stop_in_wait_in = siw;
    pulse(power_up_wr);
  endtask

  // Config bits: multi, scan, length one, length eight, then channel
  task automatic start(input logic [6:0] cfg);
    seq_cfg = cfg;
    pulse(ctrl_five_wr);
    lat = 1;
  endtask

  task automatic wait_we(input int limit);
    while (result_we !== 1'h1 && lat < limit) begin
      @(negedge clk);
      lat++;
    end
  endtask

  task automatic run(input int n);
    for (int k = 0; k < n; k++) begin
      lat = 0;
      wait_we(400);
      chk({result_we, result_slot}, {1'h1, 3'(k)});
      @(negedge clk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_format;
    logic [15:0] fmt [4];
    int          m;
    fmt = '{16'hFF00, 16'h00FF, 16'hA940, 16'h02A5};
    for (int i = 0; i < 4; i++) begin
      {res10_sel, just_right} = 2'(i);
      prescale_sel = 5'(i);
      sample_time_sel = 2'(i);
      target = res10_sel ? 10'h2A5 : 10'h3FF;
      m = (6 + (2 << i) + (res10_sel ? 12 : 10)) * 2 * (i + 1);
      start({4'h2, 3'h5});
      @(negedge clk);
      chk({afe.ph1_sample_cap, afe.mux_sel}, {1'h1, 3'h5});
      lat = 2;
      wait_we(1000);
      chk(lat >= m + 1 && lat <= m + 3, 1'h1);
      @(negedge clk);
      chk(result_word, fmt[i]);
      chk({sequence_done_flag, result_ready_flag}, 9'h101);
    end
  endtask

  task automatic t_multi;
    {res10_sel, just_right, prescale_sel, sample_time_sel} = '0;
    start({4'h8, 3'h4});
    run(4);
    chk({sequence_done_flag, result_ready_flag}, 9'h10F);
    @(negedge clk) {done_clr, ready_clr} = 9'h103;
    @(negedge clk) {done_clr, ready_clr} = 9'h000;
    chk({sequence_done_flag, result_ready_flag}, 9'h00C);
    start({4'h9, 3'h0});
    run(2);
    pulse(ctrl_four_wr);
    chk({sequence_done_flag, result_ready_flag}, 9'h000);
    run(8);
    chk({sequence_done_flag, result_ready_flag}, 9'h1FF);
  endtask

  task automatic t_pdn;
    sample_time_sel = 2'h3;
    start({4'h2, 3'h1});
    repeat (20) @(negedge clk);
    power(1'h0, 1'h0);
    repeat (3) @(negedge clk);
    chk({busy, afe.powered, regs_accessible}, 3'h1);
    lat = 0;
    wait_we(400);
    chk(result_we, 1'h0);
    power(1'h1, 1'h0);
    repeat (8) @(negedge clk);
    start({4'h2, 3'h1});
    stop_req = 1'h1;
    repeat (5) @(negedge clk);
    chk({afe.powered, busy}, 2'h0);
    stop_req = 1'h0;
    repeat (5) @(negedge clk);
    chk(afe.powered, 1'h1);
  endtask

  task automatic t_trst;
    start({4'h6, 3'h2});
    lat = 0;
    wait_we(400);
    repeat (2) @(negedge clk);
    pulse(test_rst);
    chk({power_up_ctl, busy, sequence_done_flag, result_ready_flag},
        11'h400);
  endtask

  task automatic t_wait;
    power(1'h1, 1'h1);
    chk({power_up_ctl, stop_in_wait}, 2'h3);
    start({4'h2, 3'h3});
    repeat (50) @(negedge clk);
    wait_req = 1'h1;
    repeat (300) @(negedge clk);
    chk({regs_accessible, afe.powered, result_we}, 3'h0);
    wait_req = 1'h0;
    lat = 0;
    wait_we(400);
    chk(result_we, 1'h1);
    power(1'h1, 1'h0);
    wait_req = 1'h1;
    repeat (6) @(negedge clk);
    chk({regs_accessible, afe.powered}, 2'h3);
    wait_req = 1'h0;
  endtask

  task automatic t_freeze;
    freeze_sel = 2'h3;
    start({4'h2, 3'h0});
    repeat (50) @(negedge clk);
    debug_halt_request = 1'h1;
    lat = 0;
    wait_we(200);
    chk({result_we, regs_accessible}, 2'h1);
    debug_halt_request = 1'h0;
    lat = 0;
    wait_we(200);
    chk(result_we, 1'h1);
    freeze_sel = 2'h2;
    start({4'h6, 3'h0});
    repeat (50) @(negedge clk);
    debug_halt_request = 1'h1;
    repeat (300) @(negedge clk);
    chk(busy, 1'h0);
    debug_halt_request = 1'h0;
    repeat (10) @(negedge clk);
    chk(busy, 1'h0);
    freeze_sel = 2'h0;
    debug_halt_request = 1'h1;
    start({4'h2, 3'h0});
    wait_we(400);
    chk(result_we, 1'h1);
    debug_halt_request = 1'h0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(negedge clk);
    sys_rst = 1'h0;
    @(negedge clk);
    chk({power_up_ctl, busy, sequence_done_flag, result_ready_flag},
        11'h000);
    power(1'h1, 1'h0);
    repeat (8) @(negedge clk);
    t_format;
    t_multi;
    t_pdn;
    t_trst;
    t_wait;
    t_freeze;
    stop_test;
  end

  // About seven times the expected run length
  initial begin
    #200000;
    n_fail++;
    stop_test;
  end
endmodule
`default_nettype wire
